// ### dv/rtv_core_props.sv
// Concurrent checks for the time, alarm, window and calibration block.
// Sees only the top module ports; bound to every instance at the foot.
`timescale 1ns/1ps
`default_nettype none
module rtv_core_props
  import rtv_pkg::*;
#(
  parameter int TICKS = TICKS_PER_SEC
)(
  // Clock and reset
  input wire logic        ref_clk,
  input wire logic        rst,
  // Source clock and alarm
  input wire logic        rtc_src_in,
  input wire logic        alarm_event,
  // Register port
  input wire logic [3:0]  addr,
  input wire logic [15:0] wdata,
  input wire logic        wr_stb,
  input wire logic        rd_stb,
  input wire logic [15:0] rdata,
  // Status
  input wire logic        value_write_enable,
  input wire logic        stab_window_active,
  input wire logic        samp_window_active,
  input wire logic        second_pulse
);
  logic       pwc_q;
  logic [7:0] stab_q;
  logic [7:0] samp_q;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  // Shadow of power control enable and window lengths
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      pwc_q  <= 1'b0;
      stab_q <= 8'h00;
      samp_q <= 8'h00;
    end
    else
    begin
      if (wr_stb && addr == ADDR_PWR_CTRL)
        pwc_q <= wdata[PWR_EN_BIT];
      if (wr_stb && addr == ADDR_PWR_WIN && value_write_enable)
      begin
        stab_q <= wdata[15:8];
        samp_q <= wdata[7:0];
      end
    end
  end

  // Read-back layout of the value words
  chk_year_read: assert property
    (rd_stb && addr == ADDR_YEAR |=> rdata[15:8] == 8'h00
     && rdata[7:4] <= 4'h9 && rdata[3:0] <= 4'h9)
    else $error("year read out of range");
  chk_mday_read: assert property
    (rd_stb && addr == ADDR_MONTH_DAY |=> (rdata & ~MASK_MONTH_DAY) == 16'h0
     && rdata[11:8] <= 4'h9 && rdata[3:0] <= 4'h9)
    else $error("month day read out of range");
  chk_wkhr_read: assert property
    (rd_stb && addr == ADDR_WEEKDAY_CODE_HOUR |=> (rdata & ~MASK_WEEKDAY_CODE_HOUR) == 16'h0
     && rdata[10:8] <= 3'h6 && rdata[5:4] <= 2'h2)
    else $error("weekday hour read out of range");
  chk_mnsc_read: assert property
    (rd_stb && addr == ADDR_MIN_SEC |=> (rdata & ~MASK_MIN_SEC) == 16'h0
     && rdata[14:12] <= 3'h5 && rdata[6:4] <= 3'h5)
    else $error("minute second read out of range");
  // Write enable copy and second pulse
  chk_wren_copy: assert property
    (wr_stb && addr == ADDR_CFG_CAL |=>
     value_write_enable == $past(wdata[CFG_WREN_BIT]))
    else $error("write enable not taken from config write");
  chk_pulse_single: assert property
    (second_pulse |=> !second_pulse)
    else $error("second pulse longer than one cycle");
  // Power window sequencing
  chk_stab_start: assert property
    (alarm_event && pwc_q && stab_q != 8'h00 |=> stab_window_active)
    else $error("stability window did not start on alarm");
  chk_samp_direct: assert property
    (alarm_event && pwc_q && stab_q == 8'h00 && samp_q != 8'h00 |=>
     samp_window_active && !stab_window_active)
    else $error("sample window did not start on alarm");
  chk_samp_after: assert property
    ($fell(stab_window_active) && pwc_q && samp_q != 8'h00 |->
     samp_window_active)
    else $error("sample window did not follow stability window");
  chk_samp_always: assert property
    (samp_q == 8'hff && $past(samp_q) == 8'hff |-> samp_window_active)
    else $error("all-ones sample setting not held open");

  cov_second: cover property (second_pulse);
  cov_handover: cover property
    ($fell(stab_window_active) && samp_window_active);
  cov_locked: cover property
    (wr_stb && addr == ADDR_YEAR && !value_write_enable);
endmodule : rtv_core_props

bind rtv_core rtv_core_props #(.TICKS(TICKS)) u_rtv_props (
  .ref_clk(ref_clk), .rst(rst), .rtc_src_in(rtc_src_in),
  .alarm_event(alarm_event), .addr(addr), .wdata(wdata),
  .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
  .value_write_enable(value_write_enable),
  .stab_window_active(stab_window_active),
  .samp_window_active(samp_window_active), .second_pulse(second_pulse)
);
`default_nettype wire

// ### dv/test_rtv_core.sv
// Self-checking bench for the time, alarm, window and calibration block.
// Drives every port itself; a source tick comes every 8 reference cycles.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) \
  begin \
    samples_checked++; \
    if ((g) !== (e)) \
    begin \
      fail_count++; \
      $display("[FAIL] %s expected %h seen %h", nm, e, g); \
    end \
  end
module test_rtv_core
  import rtv_pkg::*;
;
  localparam int TICKS = 8;
  localparam int P     = 8;
  typedef struct packed {logic w; logic [3:0] a; logic [15:0] v;} rtv_row_type;
  typedef struct packed {logic [7:0] cal; logic [7:0] sec; int t;}
    rtv_cal_type;
  typedef struct packed {logic [15:0] ctrl; logic [15:0] win;} rtv_win_type;

  logic        ref_clk;
  logic        rst;
  logic        rtc_src_in;
  logic        alarm_event;
  logic [3:0]  addr;
  logic [15:0] wdata;
  logic        wr_stb;
  logic        rd_stb;
  logic [15:0] rdata;
  logic        value_write_enable;
  logic        stab_window_active;
  logic        samp_window_active;
  logic        second_pulse;
  logic [2:0]  src_div;
  int          fail_count;
  int          samples_checked;
  int          n;

  // Writes then read-backs; reads carry expected values
  rtv_row_type rows [39] = '{
    '{1'b1, 4'h8, 16'h2000}, '{1'b1, 4'h0, 16'hff99},
    '{1'b0, 4'h0, 16'h0099},
    '{1'b1, 4'h1, 16'hf2f1},
    '{1'b0, 4'h1, 16'h1231},
    '{1'b1, 4'h2, 16'hfee3},
    '{1'b0, 4'h2, 16'h0623},
    '{1'b1, 4'h3, 16'hd9d9},
    '{1'b0, 4'h3, 16'h5959},
    '{1'b1, 4'h4, 16'hf2f1},
    '{1'b0, 4'h4, 16'h1231},
    '{1'b1, 4'h5, 16'hfee3},
    '{1'b0, 4'h5, 16'h0623},
    '{1'b1, 4'h6, 16'hd9d9},
    '{1'b0, 4'h6, 16'h5959},
    '{1'b1, 4'h7, 16'h0305},
    '{1'b0, 4'h7, 16'h0305},
    '{1'b1, 4'hc, 16'hffff}, '{1'b0, 4'hc, 16'h0000},
    '{1'b1, 4'h8, 16'h2300},
    '{1'b0, 4'h9, 16'h0099},
    '{1'b0, 4'ha, 16'h1231},
    '{1'b0, 4'h9, 16'h1231},
    '{1'b0, 4'h9, 16'h0623},
    '{1'b0, 4'h9, 16'h5959},
    '{1'b0, 4'h9, 16'h5959},
    '{1'b1, 4'h8, 16'h0000}, '{1'b1, 4'h0, 16'h0011},
    '{1'b0, 4'h0, 16'h0099},
    '{1'b1, 4'h1, 16'h0011},
    '{1'b0, 4'h1, 16'h1231},
    '{1'b1, 4'h4, 16'h0011},
    '{1'b0, 4'h4, 16'h1231},
    '{1'b1, 4'h7, 16'h0011},
    '{1'b0, 4'h7, 16'h0305},
    '{1'b1, 4'h6, 16'h0102}, '{1'b0, 4'h6, 16'h0102},
    '{1'b1, 4'h8, 16'h8000},
    '{1'b0, 4'h8, 16'h0000}
  };
  // Calibration value, start second, ticks in the second that follows it
  rtv_cal_type cals [4] = '{'{8'h02, 8'h59, 6}, '{8'hfd, 8'h14, 11},
                            '{8'h02, 8'h15, 8}, '{8'h00, 8'h44, 8}};
  // Power control word and window lengths
  rtv_win_type wins [4] = '{'{16'h8000, 16'h0305}, '{16'hb000, 16'h0203},
                            '{16'h8000, 16'h0004}, '{16'h0000, 16'h0305}};

  rtv_core #(.TICKS(TICKS)) DUT (
    .ref_clk(ref_clk), .rst(rst), .rtc_src_in(rtc_src_in),
    .alarm_event(alarm_event), .addr(addr), .wdata(wdata),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
    .value_write_enable(value_write_enable),
    .stab_window_active(stab_window_active),
    .samp_window_active(samp_window_active), .second_pulse(second_pulse)
  );

  // Reference clock
  always #2.5 ref_clk = ~ref_clk;

  // Source clock, four cycles high and four low
  always @(posedge ref_clk)
  begin
    src_div    <= src_div + 3'h1;
    rtc_src_in <= src_div[2];
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : summarize

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    addr   <= a;
    wdata  <= d;
    wr_stb <= 1'b1;
    @(posedge ref_clk);
    wr_stb <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    @(posedge ref_clk);
    addr   <= a;
    rd_stb <= 1'b1;
    @(posedge ref_clk);
    rd_stb <= 1'b0;
    #1;
    `CHK("read word", e, rdata)
  endtask : rd

  // Cycles up to and including the next second pulse
  task automatic wait_pulse(output int k);
    k = 0;
    do
    begin
      @(posedge ref_clk);
      #1;
      k++;
    end
    while (second_pulse !== 1'b1 && k < 2000);
    if (k >= 2000)
    begin
      fail_count++;
      summarize();
    end
  endtask : wait_pulse

  // One alarm, then measure both windows in reference cycles
  task automatic win_run(input logic [15:0] ctrl, input logic [15:0] win);
    int n1;
    int n2;
    int p;
    int sl;
    int sa;
    logic samp_ok;
    p  = ctrl[13] ? 2 * P : P;
    sl = ctrl[15] ? int'(win[15:8]) : 0;
    sa = ctrl[15] ? int'(win[7:0]) : 0;
    n1 = 0;
    n2 = 0;
    wr(ADDR_PWR_WIN, win);
    wr(ADDR_PWR_CTRL, ctrl);
    @(posedge ref_clk);
    alarm_event <= 1'b1;
    @(posedge ref_clk);
    alarm_event <= 1'b0;
    #1;
    while (stab_window_active === 1'b1 && n1 < 3000)
    begin
      @(posedge ref_clk);
      #1;
      n1++;
    end
    while (samp_window_active === 1'b1 && n2 < 3000)
    begin
      @(posedge ref_clk);
      #1;
      n2++;
    end
    // A window that never closes is a hang: report and stop
    if (n1 >= 3000 || n2 >= 3000)
    begin
      fail_count++;
      summarize();
    end
    samp_ok = sl > 0 ? n2 == sa * p : n2 > (sa - 1) * p && n2 <= sa * p;
    `CHK("stability length", 1'b1, n1 > (sl - 1) * p && n1 <= sl * p)
    `CHK("sample length", 1'b1, samp_ok)
  endtask : win_run

  // Main sequence
  initial
  begin
    ref_clk = 1'b0;
    rst = 1'b1;
    rtc_src_in = 1'b0;
    src_div = 3'h0;
    alarm_event = 1'b0;
    addr = 4'h0;
    wdata = 16'h0000;
    wr_stb = 1'b0;
    rd_stb = 1'b0;
    fail_count = 0;
    samples_checked = 0;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    rd(ADDR_YEAR, RST_YEAR);
    rd(ADDR_MONTH_DAY, RST_MONTH_DAY);
    rd(ADDR_MIN_SEC, RST_ZERO);
    foreach (rows[i])
      if (rows[i].w)
        wr(rows[i].a, rows[i].v);
      else
        rd(rows[i].a, rows[i].v);
    // Roll over from 99-12-31 weekday 6 23:59:59
    wr(ADDR_CFG_CAL, 16'h2000);
    wr(ADDR_CFG_CAL, 16'ha000);
    wait_pulse(n);
    rd(ADDR_YEAR, 16'h0000);
    rd(ADDR_MONTH_DAY, 16'h0101);
    rd(ADDR_WEEKDAY_CODE_HOUR, 16'h0000);
    rd(ADDR_MIN_SEC, 16'h0000);
    // Second length after each calibration point
    foreach (cals[i])
    begin
      wr(ADDR_CFG_CAL, {8'h20, cals[i].cal});
      wr(ADDR_MIN_SEC, {8'h00, cals[i].sec});
      wr(ADDR_CFG_CAL, {8'ha0, cals[i].cal});
      wait_pulse(n);
      wait_pulse(n);
      `CHK("second length", cals[i].t * P, n)
    end
    // Half second flag set late in a second, cleared by a seconds write
    wait_pulse(n);
    repeat (40) @(posedge ref_clk);
    rd(ADDR_CFG_CAL, 16'ha800);
    wr(ADDR_MIN_SEC, 16'h0000);
    rd(ADDR_CFG_CAL, 16'ha000);
    foreach (wins[i])
      win_run(wins[i].ctrl, wins[i].win);
    wr(ADDR_PWR_WIN, 16'h00ff);
    wr(ADDR_PWR_CTRL, 16'h0000);
    repeat (2) @(posedge ref_clk);
    #1;
    `CHK("sample always open", 1'b1, samp_window_active)
    // Reset in mid-run, raised right after a clock edge
    @(posedge ref_clk);
    rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    rd(ADDR_YEAR, RST_YEAR);
    `CHK("write enable after reset", 1'b0, value_write_enable)
    summarize();
  end
endmodule : test_rtv_core
`undef CHK
`default_nettype wire

// ### rtl/rtv_core.sv
// Time/date value registers, alarm value registers, power window timer
// and drift calibration. Assumes a source clock pin slower than ref_clk
// and alarm events arriving as one-cycle pulses on the ref_clk domain.
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// RULE1 - Year holds tens digit in 7-4, ones digit in 3-0.
// RULE2 - Month tens is bit 12, month ones in 11-8.
// RULE3 - Day tens in 5-4, day ones in 3-0.
// RULE4 - Weekday is bits 10-8, values 0 to 6.
// RULE5 - Hour tens in 5-4, hour ones in 3-0.
// RULE6 - Minute tens in 14-12, minute ones in 11-8.
// RULE7 - Second tens in 6-4, second ones in 3-0.
// RULE8 - Unused bits of value words read as zero.
// RULE9 - Year, month/day, weekday/hour, window timer writes need write enable.
// RULE10 - Alarm words share time layouts; alarm date writes need write enable.
// RULE11 - Stability length in 15-8 counts window clock periods.
// RULE12 - With power control on, alarm event starts stability window.
// RULE13 - Sample length in 7-0; all ones keeps sample window always open.
// RULE14 - Sample starts at stability end, or at alarm when stability zero.
// RULE15 - Signed calibration times four applied to timer each minute.
// RULE16 - Negative calibration removes pulses each minute; here a negative value adds pulses and a positive one removes them.
// RULE17 - Software writes calibration only at safe moments.
// RULE18 - Adjustment happens at seconds 00, 15, 30 and 45.
// RULE19 - Software derives calibration from measured frequency error.
// RULE20 - Calibration range is plus 508 to minus 512 pulses per minute.
// RULE21 - Window pointer decrements on high word access, stops at 00.
// RULE22 - Time value words locked unless write enable is set.
// RULE23 - Writing seconds clears the half second flag.
// RULE24 - Time advances once a second with BCD carries; weekday wraps.
// RULE25 - Window clock is source clock divided by one or two.
module rtv_core
  import rtv_pkg::*;
#(
  parameter int TICKS = TICKS_PER_SEC
)(
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst,
  // Real-time source clock pin
  input  wire logic        rtc_src_in,
  // Alarm event from the alarm logic, one cycle
  input  wire logic        alarm_event,
  // Register port
  input  wire logic [3:0]  addr,
  input  wire logic [15:0] wdata,
  input  wire logic        wr_stb,
  input  wire logic        rd_stb,
  output logic      [15:0] rdata,
  // Status to the surrounding logic
  output logic             value_write_enable,
  output logic             stab_window_active,
  output logic             samp_window_active,
  output logic             second_pulse
);

  localparam logic [17:0] TOP  = 18'(TICKS - 1);
  localparam logic [17:0] HALF = 18'(TICKS / 2);

  rtv_state_type q;
  rtv_state_type d;

  // BCD increment of a two-digit value
  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    logic [7:0] r;
    r = v;
    if (v[3:0] == 4'h9)
      r = {v[7:4] + 4'h1, 4'h0};
    else
      r[3:0] = v[3:0] + 4'h1;
    return r;
  endfunction : bcd_inc

  // Last day of a BCD month, leap years every fourth BCD year
  function automatic logic [7:0] last_day(input logic [7:0] mon,
                                          input logic [7:0] yr);
    logic leap;
    leap = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6)
                 : (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 ||
                    yr[3:0] == 4'h8);
    case (mon)
      8'h02:   last_day = leap ? 8'h29 : 8'h28;
      8'h04,
      8'h06,
      8'h09,
      8'h11:   last_day = 8'h30;
      default: last_day = 8'h31;
    endcase
  endfunction : last_day

  // Word selected by the value window pointer
  function automatic logic [15:0] win_word(input rtv_state_type s);
    case (s.ptr)
      2'h0:    win_word = s.min_sec;
      2'h1:    win_word = s.weekday_code_hour;
      2'h2:    win_word = s.month_day;
      default: win_word = s.year;
    endcase
  endfunction : win_word

  // Next state of the whole block
  always_comb
  begin
    logic        src_tick;
    logic        sec_tick;
    logic        stab_tick;
    logic        samp_tick;
    logic        day_carry;
    logic [7:0]  s_sec;
    logic [7:0]  s_min;
    logic [7:0]  s_hr;
    logic [7:0]  s_day;
    logic [7:0]  s_mon;
    logic [7:0]  s_yr;
    logic [2:0]  s_wd;
    logic        wr;
    logic        wr_time;
    src_tick  = 1'b0;
    sec_tick  = 1'b0;
    stab_tick = 1'b0;
    samp_tick = 1'b0;
    day_carry = 1'b0;
    s_sec     = q.min_sec[7:0];
    s_min     = q.min_sec[15:8];
    s_hr      = q.weekday_code_hour[7:0];
    s_wd      = q.weekday_code_hour[10:8];
    s_day     = q.month_day[7:0];
    s_mon     = q.month_day[15:8];
    s_yr      = q.year[7:0];
    wr        = wr_stb;
    wr_time   = wr_stb & q.wren;                              // RULE22
    d         = q;

    // Two-flop synchroniser and rising edge of the source clock
    d.src_meta = rtc_src_in;
    d.src_sync = q.src_meta;
    d.src_prev = q.src_sync;
    src_tick   = q.src_sync & ~q.src_prev;

    // Prescaler to seconds, with calibration preload each quarter minute
    d.sec_pulse = 1'b0;
    if (q.timer_en && src_tick)
    begin
      if ($signed(q.presc) >= $signed(TOP))
      begin
        sec_tick    = 1'b1;
        d.sec_pulse = 1'b1;
        d.presc     = 18'h00000;
      end
      else
      begin
        d.presc = q.presc + 18'h00001;
      end
    end

    // BCD time advance with carries                             RULE24
    if (sec_tick)
    begin
      if (s_sec == 8'h59)
      begin
        s_sec = 8'h00;
        if (s_min == 8'h59)
        begin
          s_min = 8'h00;
          if (s_hr == 8'h23)
          begin
            s_hr      = 8'h00;
            day_carry = 1'b1;
          end
          else
            s_hr = bcd_inc(s_hr);
        end
        else
          s_min = bcd_inc(s_min);
      end
      else
        s_sec = bcd_inc(s_sec);
      if (day_carry)
      begin
        s_wd = (s_wd >= 3'h6) ? 3'h0 : s_wd + 3'h1;            // RULE4
        if (s_day == last_day(s_mon, s_yr))
        begin
          s_day = 8'h01;
          if (s_mon == 8'h12)
          begin
            s_mon = 8'h01;
            s_yr  = (s_yr == 8'h99) ? 8'h00 : bcd_inc(s_yr);
          end
          else
            s_mon = bcd_inc(s_mon);
        end
        else
          s_day = bcd_inc(s_day);
      end
      // Quarter-minute calibration: four per minute gives cal times four
      if (s_sec == 8'h00 || s_sec == 8'h15 ||
          s_sec == 8'h30 || s_sec == 8'h45)                     // RULE18
      begin
        d.presc = {{10{q.cal[7]}}, q.cal};          // RULE15 RULE16 RULE20
      end
      d.min_sec   = {s_min, s_sec} & MASK_MIN_SEC;              // RULE6 RULE7
      d.weekday_code_hour = {5'h00, s_wd, s_hr} & MASK_WEEKDAY_CODE_HOUR;       // RULE5
      d.month_day = {s_mon, s_day} & MASK_MONTH_DAY;            // RULE2 RULE3
      d.year      = {8'h00, s_yr} & MASK_YEAR;                  // RULE1
    end

    // Half second flag from the prescaler position
    d.half = $signed(d.presc) >= $signed(HALF);

    // Register writes; masks keep unused bits at zero             RULE8
    if (wr)
    begin
      case (addr)
        ADDR_YEAR:
          if (wr_time)
            d.year = wdata & MASK_YEAR;                         // RULE9 RULE1
        ADDR_MONTH_DAY:
          if (wr_time)
            d.month_day = wdata & MASK_MONTH_DAY;               // RULE9
        ADDR_WEEKDAY_CODE_HOUR:
          if (wr_time)
            d.weekday_code_hour = wdata & MASK_WEEKDAY_CODE_HOUR;               // RULE9
        ADDR_MIN_SEC:
          if (wr_time)
          begin
            d.min_sec = wdata & MASK_MIN_SEC;
            d.presc   = 18'h00000;                              // RULE23
            d.half    = 1'b0;                                   // RULE23
          end
        ADDR_AL_MD:
          if (q.wren)
            d.al_md = wdata & MASK_MONTH_DAY;                   // RULE10
        ADDR_AL_WH:
          if (q.wren)
            d.al_wh = wdata & MASK_WEEKDAY_CODE_HOUR;                   // RULE10
        ADDR_AL_MS:
          d.al_ms = wdata & MASK_MIN_SEC;                       // RULE10
        ADDR_PWR_WIN:
          if (q.wren)
          begin
            d.stab_len = wdata[15:8];                           // RULE9 RULE11
            d.samp_len = wdata[7:0];                            // RULE13
          end
        ADDR_CFG_CAL:
        begin
          if (q.wren)
            d.timer_en = wdata[CFG_TIMER_EN_BIT];
          d.wren = wdata[CFG_WREN_BIT];
          d.ptr  = wdata[CFG_PTR_LSB +: 2];
          d.cal  = wdata[7:0];
        end
        ADDR_WIN_HIGH,
        ADDR_WIN_LOW:
          if (wr_time)
          begin
            case (q.ptr)
              2'h0:
              begin
                d.min_sec = wdata & MASK_MIN_SEC;
                d.presc   = 18'h00000;                          // RULE23
                d.half    = 1'b0;
              end
              2'h1:    d.weekday_code_hour = wdata & MASK_WEEKDAY_CODE_HOUR;
              2'h2:    d.month_day = wdata & MASK_MONTH_DAY;
              default: d.year      = wdata & MASK_YEAR;
            endcase
          end
        ADDR_PWR_CTRL:
        begin
          d.pwc_en   = wdata[PWR_EN_BIT];
          d.stab_div = wdata[PWR_STAB_DIV_BIT];
          d.samp_div = wdata[PWR_SAMP_DIV_BIT];
        end
        default: ;
      endcase
    end

    // Window pointer steps down on any high-word access, stops at 00   RULE21
    if ((wr || rd_stb) && addr == ADDR_WIN_HIGH && q.ptr != PTR_MIN_SEC)
      d.ptr = q.ptr - 2'h1;

    // Read data stands in the cycle after the read strobe only
    d.rdata = 16'h0000;
    if (rd_stb)
    begin
      case (addr)
        ADDR_YEAR:      d.rdata = q.year;
        ADDR_MONTH_DAY: d.rdata = q.month_day;
        ADDR_WEEKDAY_CODE_HOUR: d.rdata = q.weekday_code_hour;
        ADDR_MIN_SEC:   d.rdata = q.min_sec;
        ADDR_AL_MD:     d.rdata = q.al_md;
        ADDR_AL_WH:     d.rdata = q.al_wh;
        ADDR_AL_MS:     d.rdata = q.al_ms;
        ADDR_PWR_WIN:   d.rdata = {q.stab_len, q.samp_len};
        ADDR_CFG_CAL:   d.rdata = {q.timer_en, 1'b0, q.wren, 1'b0, q.half,
                                   1'b0, q.ptr, q.cal};
        ADDR_WIN_HIGH,
        ADDR_WIN_LOW:   d.rdata = win_word(q);
        ADDR_PWR_CTRL:  d.rdata = {q.pwc_en, 1'b0, q.stab_div, q.samp_div,
                                   12'h000};
        default:        d.rdata = 16'h0000;
      endcase
    end

    // Window clock: source ticks divided by one or two           RULE25
    if (src_tick)
      d.div_tog = ~q.div_tog;
    stab_tick = src_tick & (~q.stab_div | q.div_tog);           // RULE25
    samp_tick = src_tick & (~q.samp_div | q.div_tog);           // RULE25

    // Stability window count-down, then hand over to the sample window
    if (q.stab_act && stab_tick)
    begin
      if (q.stab_cnt <= 8'h01)
      begin
        d.stab_act = 1'b0;
        d.stab_cnt = 8'h00;
        d.samp_cnt = q.samp_len;                                // RULE14
        d.samp_act = q.samp_len != 8'h00;
      end
      else
      begin
        d.stab_cnt = q.stab_cnt - 8'h01;                        // RULE11
      end
    end

    // Sample window count-down
    if (q.samp_act && samp_tick)
    begin
      if (q.samp_cnt <= 8'h01)
      begin
        d.samp_act = 1'b0;
        d.samp_cnt = 8'h00;
      end
      else
      begin
        d.samp_cnt = q.samp_cnt - 8'h01;                        // RULE13
      end
    end

    // Alarm event restarts the windows while power control is on
    if (alarm_event && q.pwc_en)
    begin
      if (q.stab_len != 8'h00)
      begin
        d.stab_act = 1'b1;                                      // RULE12
        d.stab_cnt = q.stab_len;                                // RULE11
        d.samp_act = 1'b0;
        d.samp_cnt = 8'h00;
      end
      else
      begin
        d.stab_act = 1'b0;
        d.samp_cnt = q.samp_len;                                // RULE14
        d.samp_act = q.samp_len != 8'h00;
      end
    end

    // Power control off stops the stability timer, and the sample timer unless its length is all ones
    if (!q.pwc_en)
    begin
      d.stab_act = 1'b0;
      d.samp_act = 1'b0;
    end

    // All-ones sample setting holds the sample window open
    if (d.samp_len == SAMP_ALWAYS)
      d.samp_act = 1'b1;                                        // RULE13
  end

  // State register with synchronous reset
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      q           <= '0;
      q.year      <= RST_YEAR;
      q.month_day <= RST_MONTH_DAY;
      q.weekday_code_hour <= RST_ZERO;
      q.min_sec   <= RST_ZERO;
    end
    else
    begin
      q <= d;
    end
  end

  // Outputs straight from the state register
  assign rdata              = q.rdata;
  assign value_write_enable = q.wren;
  assign stab_window_active = q.stab_act;
  assign samp_window_active = q.samp_act;
  assign second_pulse       = q.sec_pulse;

endmodule : rtv_core

`default_nettype wire

// ### rtl/rtv_pkg.sv
// Package for the time, alarm, window-timer and calibration block.
// Assumes one 200 MHz clock and a 16-bit register port with addresses below.
package rtv_pkg;

  // Register word addresses on the plain register port
  localparam logic [3:0] ADDR_YEAR       = 4'h0;
  localparam logic [3:0] ADDR_MONTH_DAY  = 4'h1;
  localparam logic [3:0] ADDR_WEEKDAY_CODE_HOUR  = 4'h2;
  localparam logic [3:0] ADDR_MIN_SEC    = 4'h3;
  localparam logic [3:0] ADDR_AL_MD      = 4'h4;
  localparam logic [3:0] ADDR_AL_WH      = 4'h5;
  localparam logic [3:0] ADDR_AL_MS      = 4'h6;
  localparam logic [3:0] ADDR_PWR_WIN    = 4'h7;
  localparam logic [3:0] ADDR_CFG_CAL    = 4'h8;
  localparam logic [3:0] ADDR_WIN_HIGH   = 4'h9;
  localparam logic [3:0] ADDR_WIN_LOW    = 4'ha;
  localparam logic [3:0] ADDR_PWR_CTRL   = 4'hb;

  // Implemented bits of each value word; the rest read zero
  localparam logic [15:0] MASK_YEAR      = 16'h00ff;
  localparam logic [15:0] MASK_MONTH_DAY = 16'h1f3f;
  localparam logic [15:0] MASK_WEEKDAY_CODE_HOUR = 16'h073f;
  localparam logic [15:0] MASK_MIN_SEC   = 16'h7f7f;

  // Configuration/calibration word bit positions
  localparam int CFG_TIMER_EN_BIT  = 15;
  localparam int CFG_WREN_BIT      = 13;
  localparam int CFG_HALF_BIT      = 11;
  localparam int CFG_PTR_LSB       = 8;
  // Power control word bit positions
  localparam int PWR_EN_BIT        = 15;
  localparam int PWR_STAB_DIV_BIT  = 13;
  localparam int PWR_SAMP_DIV_BIT  = 12;

  // Values after reset: 00-01-01, weekday 0, 00:00:00
  localparam logic [15:0] RST_YEAR       = 16'h0000;
  localparam logic [15:0] RST_MONTH_DAY  = 16'h0101;
  localparam logic [15:0] RST_ZERO       = 16'h0000;

  // Source clock ticks per second and the all-ones sample setting
  localparam int          TICKS_PER_SEC  = 32768;
  localparam logic [7:0]  SAMP_ALWAYS    = 8'hff;
  localparam logic [1:0]  PTR_MIN_SEC    = 2'h0;

  // Whole state of the block
  typedef struct packed {
    logic        src_meta;
    logic        src_sync;
    logic        src_prev;
    logic [15:0] year;
    logic [15:0] month_day;
    logic [15:0] weekday_code_hour;
    logic [15:0] min_sec;
    logic [15:0] al_md;
    logic [15:0] al_wh;
    logic [15:0] al_ms;
    logic [7:0]  stab_len;
    logic [7:0]  samp_len;
    logic        timer_en;
    logic        wren;
    logic [1:0]  ptr;
    logic [7:0]  cal;
    logic        pwc_en;
    logic        stab_div;
    logic        samp_div;
    logic [17:0] presc;
    logic        half;
    logic        div_tog;
    logic [7:0]  stab_cnt;
    logic [7:0]  samp_cnt;
    logic        stab_act;
    logic        samp_act;
    logic        sec_pulse;
    logic [15:0] rdata;
  } rtv_state_type;

endpackage : rtv_pkg
